// *** hw/shbs_pkg.sv ***
// Purpose: constants and types shared by the stop/halt/brake sequencer
// Assumes: one 50 MHz system clock, synchronous active-low reset
// Notes:   parameter offsets are word addresses on the parameter port
package shbs_pkg;
  localparam int          CLK_FREQ_HZ      = 50_000_000;
  localparam int          TICK_PERIOD_MS   = 1;
  localparam int          MS_TICK_CYCLES   =
    CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
  localparam int          PAR_AW           = 16;
  localparam int          PAR_DW           = 16;

  localparam logic [15:0] OFS_REL_DELAY    = 16'h050e;
  localparam logic [15:0] OFS_APPLY_DELAY  = 16'h0510;
  localparam logic [15:0] OFS_FSTOP_LIM    = 16'h110a;
  localparam logic [15:0] OFS_HALT_LIM     = 16'h110c;
  localparam logic [15:0] OFS_STATUS       = 16'h0600;

  localparam logic [15:0] RST_REL_DELAY    = 16'h0000;
  localparam logic [15:0] RST_APPLY_DELAY  = 16'h0000;
  localparam logic [15:0] RST_FSTOP_LIM    = 16'h0064;
  localparam logic [15:0] RST_HALT_LIM     = 16'h0064;
  localparam logic [15:0] MAX_DELAY_MS     = 16'h03e8;
  localparam logic [15:0] CUR_UNLIMITED    = 16'hffff;

  // status register field positions
  localparam int          ST_AMP_BIT       = 0;
  localparam int          ST_BRK_BIT       = 1;
  localparam int          ST_MOT_BIT       = 2;
  localparam int          ST_HALT_BIT      = 3;
  localparam int          ST_FSTOP_BIT     = 4;
  localparam int          ST_OV_BIT        = 5;
  localparam int          ST_CLS2_BIT      = 6;
  localparam int          ST_HOLD_BIT      = 7;

  typedef enum logic [8:0] {
    S_OFF     = 9'h001,
    S_RELEASE = 9'h002,
    S_RUN     = 9'h004,
    S_FSTOP   = 9'h008,
    S_FHOLD   = 9'h010,
    S_HALT    = 9'h020,
    S_COMP    = 9'h040,
    S_HHOLD   = 9'h080,
    S_APPLY   = 9'h100
  } shbs_state_t;
endpackage

// *** hw/shbs_tmr_if.sv ***
// Purpose: link between sequencer and its millisecond delay timer
// Assumes: both ends on the system clock
// Notes:   restart is a one-cycle pulse, done is a level
`timescale 1ns/100ps
interface shbs_tmr_if;
  logic        restart;
  logic [15:0] delay_ms;
  logic        done;
  modport seq (output restart, output delay_ms, input done);
  modport tmr (input restart, input delay_ms, output done);
endinterface

// *** hw/shbs_ms_timer.sv ***
// Purpose: millisecond tick and delay counter for brake timing
// Assumes: delay_ms stays stable while a delay runs
// Notes:   zero delay reports done straight away
`timescale 1ns/100ps
module shbs_ms_timer
  import shbs_pkg::*;
#(
  parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
  input  wire logic clk,   // system clock
  input  wire logic rstn,  // sync reset, active low
  shbs_tmr_if.tmr   t      // delay request from sequencer
);
  logic [31:0] pre_q;
  logic [15:0] ms_q;
  wire         tick = (pre_q == 32'(TICK_CYCLES - 1));

  // counter restarts on entering each brake delay state so a delay is never short
  always_ff @(posedge clk) begin
    if (!rstn || t.restart) begin
      pre_q <= 32'h0000_0000;
      ms_q  <= 16'h0000;
    end else begin
      pre_q <= tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
      if (tick && ms_q != 16'hffff)
        ms_q <= ms_q + 16'h0001;
    end
  end

  assign t.done = (ms_q >= t.delay_ms);
endmodule

// *** hw/shbs_top.sv ***
// Purpose: fast-stop, halt and holding-brake sequencing of a servo drive
// Assumes: status inputs are synchronous to clk; standstill from motion
// Notes:   parameters are reached on a simple word-addressed port
`timescale 1ns/100ps
// Notes on behaviour
// - fault class 1/2 or software stop: fast stop
// - class 1 stop keeps amplifier on at standstill
// - class 2 disables stage only after standstill
// - bus overvoltage while braking: stage off, flag
// - fast stop brakes at fast-stop current limit
// - halt or mode end brakes at halt limit
// - halt standstill: compensate, then hold position powered
// - all halts withdrawn: resume interrupted movement
// - halt dropped mid-brake: finish stopping first
// - halt active while any source requests it
// - brake release acts only when output assigned
// - on enable: release brake, hold motion for delay
// - on disable: apply brake, keep current for delay
module shbs_top
  import shbs_pkg::*;
#(
  parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
  input  wire logic              clk,            // 50 MHz system clock
  input  wire logic              rstn,           // sync reset, active low
  input  wire logic              enable_req,     // amplifier enable wanted
  input  wire logic              fault_class1,   // class 1 fault level
  input  wire logic              fault_class2,   // class 2 fault level
  input  wire logic              sw_stop,        // software stop pulse
  input  wire logic              fault_reset,    // fault acknowledge pulse
  input  wire logic              halt_sw_req,    // software halt level
  input  wire logic              halt_n,         // halt input, active low
  input  wire logic              mode_end,       // operating mode ends
  input  wire logic              standstill,     // motor at rest
  input  wire logic              comp_done,      // compensation finished
  input  wire logic              dc_overvoltage, // bus above limit
  input  wire logic              brake_assigned, // output carries release
  input  wire logic [PAR_AW-1:0] par_addr,       // parameter address
  input  wire logic [PAR_DW-1:0] par_wdata,      // parameter write data
  input  wire logic              par_wr,         // write strobe
  input  wire logic              par_rd,         // read strobe
  output logic      [PAR_DW-1:0] par_rdata,      // read data, next cycle
  output logic                   amp_enable,     // power stage on
  output logic                   brake_release,  // brake release output
  output logic                   motion_enable,  // profile may move
  output logic      [15:0]       current_limit,  // active limit 0.01 A pk
  output logic                   pos_comp_start, // start compensation
  output logic                   pos_hold,       // position control hold
  output logic                   resume_move,    // continue after halt
  output logic                   ov_fault        // bus overvoltage flag
);
  shbs_tmr_if tif ();

  shbs_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tmr (
    .clk  (clk),
    .rstn (rstn),
    .t    (tif.tmr)
  );

  shbs_state_t state_q, state_d;
  logic [15:0] rel_dly_q, apl_dly_q, fs_lim_q, ht_lim_q;
  logic        cls2_q, ov_q;
  logic        mode_halt_q;
  logic [15:0] rdata_q;

  function automatic logic [15:0] clamp_ms(input logic [15:0] v);
    return (v > MAX_DELAY_MS) ? MAX_DELAY_MS : v;
  endfunction

  // parameter port decode
  wire wr_rel   = par_wr && (par_addr == OFS_REL_DELAY);
  wire wr_apl   = par_wr && (par_addr == OFS_APPLY_DELAY);
  wire wr_fs    = par_wr && (par_addr == OFS_FSTOP_LIM);
  wire wr_ht    = par_wr && (par_addr == OFS_HALT_LIM);

  wire halt_req = halt_sw_req || !halt_n || mode_halt_q;
  wire fstop_ev = fault_class1 || fault_class2 || sw_stop;
  wire braking  = (state_q == S_FSTOP) || (state_q == S_HALT);
  wire ov_trip  = braking && dc_overvoltage;
  wire powered  = (state_q != S_OFF);
  wire brk_on   = powered && (state_q != S_APPLY);
  wire can_stop = (state_q == S_RUN) || (state_q == S_HALT) ||
                  (state_q == S_COMP) || (state_q == S_HHOLD) ||
                  (state_q == S_RELEASE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      // stage stays off until the overvoltage flag is acknowledged
      S_OFF:
        if (enable_req && !fault_class2 && !ov_q)
          state_d = S_RELEASE;
      S_RELEASE:
        if (!enable_req)
          state_d = S_APPLY;
        else if (fstop_ev)
          state_d = S_FSTOP;
        else if (tif.done)
          state_d = S_RUN;
      S_RUN:
        if (fstop_ev)
          state_d = S_FSTOP;
        else if (!enable_req)
          state_d = S_APPLY;
        else if (halt_req)
          state_d = S_HALT;
      S_FSTOP:
        if (ov_trip)
          state_d = S_OFF;
        else if (standstill)
          state_d = (cls2_q || fault_class2) ? S_APPLY
                                             : S_FHOLD;
      S_FHOLD:
        if (fault_class2)
          state_d = S_APPLY;
        else if (!enable_req)
          state_d = S_APPLY;
        else if (fault_reset && !fault_class1)
          state_d = S_RUN;
      S_HALT:
        if (ov_trip)
          state_d = S_OFF;
        else if (fstop_ev)
          state_d = S_FSTOP;
        else if (standstill)
          state_d = S_COMP;
      S_COMP:
        if (fstop_ev)
          state_d = S_FSTOP;
        else if (comp_done)
          state_d = S_HHOLD;
      S_HHOLD:
        if (fstop_ev)
          state_d = S_FSTOP;
        else if (!enable_req)
          state_d = S_APPLY;
        else if (!halt_req)
          state_d = S_RUN;
      S_APPLY:
        if (tif.done)
          state_d = S_OFF;
      default:
        state_d = S_OFF;
    endcase
  end

  // a pending disable during fast stop waits for standstill on purpose
  always_ff @(posedge clk) begin
    if (!rstn)
      state_q <= S_OFF;
    else
      state_q <= state_d;
  end

  // the timer restarts on entering either brake delay state
  assign tif.restart  = (state_d != state_q) &&
                        ((state_d == S_RELEASE) ||
                         (state_d == S_APPLY));
  assign tif.delay_ms = (state_q == S_APPLY || state_d == S_APPLY)
                        ? apl_dly_q : rel_dly_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rel_dly_q <= RST_REL_DELAY;
      apl_dly_q <= RST_APPLY_DELAY;
      fs_lim_q  <= RST_FSTOP_LIM;
      ht_lim_q  <= RST_HALT_LIM;
    end else begin
      if (wr_rel) rel_dly_q <= clamp_ms(par_wdata);
      if (wr_apl) apl_dly_q <= clamp_ms(par_wdata);
      if (wr_fs)  fs_lim_q  <= par_wdata;
      if (wr_ht)  ht_lim_q  <= par_wdata;
    end
  end

  // class 2 cause is kept for the whole stop; overvoltage set beats clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cls2_q      <= 1'b0;
      ov_q        <= 1'b0;
      mode_halt_q <= 1'b0;
    end else begin
      if (state_q == S_FSTOP || state_q == S_FHOLD)
        cls2_q <= cls2_q || fault_class2;
      else
        cls2_q <= fault_class2 && can_stop;
      ov_q <= ov_trip || (ov_q && !fault_reset);
      if (mode_end && state_q == S_RUN)
        mode_halt_q <= 1'b1;
      else if (state_q == S_OFF || enable_req == 1'b0)
        mode_halt_q <= 1'b0;
    end
  end

  wire [15:0] status_w = {8'h00,
    (state_q == S_HHOLD), cls2_q, ov_q,
    (state_q == S_FSTOP || state_q == S_FHOLD),
    halt_req, (state_q == S_RUN), brake_release, powered};

  always_ff @(posedge clk) begin
    if (!rstn)
      rdata_q <= 16'h0000;
    else if (par_rd) begin
      case (par_addr)
        OFS_REL_DELAY:   rdata_q <= rel_dly_q;
        OFS_APPLY_DELAY: rdata_q <= apl_dly_q;
        OFS_FSTOP_LIM:   rdata_q <= fs_lim_q;
        OFS_HALT_LIM:    rdata_q <= ht_lim_q;
        OFS_STATUS:      rdata_q <= status_w;
        default:         rdata_q <= 16'h0000;
      endcase
    end
  end

  assign par_rdata      = rdata_q;
  assign amp_enable     = powered;
  assign brake_release  = brk_on && brake_assigned;
  assign motion_enable  = (state_q == S_RUN);
  assign current_limit  =
    (state_q == S_FSTOP) ? fs_lim_q :
    (state_q == S_HALT)  ? ht_lim_q : CUR_UNLIMITED;
  assign pos_comp_start = (state_q == S_COMP);
  assign pos_hold       = (state_q == S_HHOLD) ||
                          (state_q == S_FHOLD);
  assign resume_move    = (state_q == S_HHOLD) &&
                          (state_d == S_RUN);
  assign ov_fault       = ov_q;
endmodule

// *** verification/shbs_properties.sv ***
// Purpose: port-level checks of the stop/halt/brake sequencer
// Assumes: outputs follow the state register combinationally
// Notes:   bound to every shbs_top instance
`timescale 1ns/100ps
module shbs_properties (
  input wire logic        clk,            // system clock
  input wire logic        rstn,           // sync reset, active low
  input wire logic        enable_req,     // enable wanted
  input wire logic        fault_class1,   // class 1 fault
  input wire logic        fault_class2,   // class 2 fault
  input wire logic        halt_n,         // halt input, active low
  input wire logic        standstill,     // motor at rest
  input wire logic        dc_overvoltage, // bus over limit
  input wire logic        brake_assigned, // release routed out
  input wire logic        amp_enable,     // power stage on
  input wire logic        brake_release,  // brake release
  input wire logic        motion_enable,  // profile may move
  input wire logic [15:0] current_limit,  // active limit
  input wire logic        pos_hold,       // position hold
  input wire logic        resume_move,    // resume pulse
  input wire logic        ov_fault        // overvoltage flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_fault_stops: assert property (
    motion_enable && fault_class1 |=>
    !motion_enable && current_limit != 16'hffff) else $error("no stop");
  a_cls2_stays_on: assert property (
    motion_enable && fault_class2 ##1 !standstill && !dc_overvoltage
    |-> amp_enable) else $error("early off");
  a_ov_kills: assert property ($rose(ov_fault) |-> !amp_enable)
    else $error("stage on in overvoltage");
  a_ov_blocks: assert property (ov_fault |-> !amp_enable)
    else $error("stage on while flag stands");
  a_halt_brakes: assert property (
    motion_enable && !halt_n && enable_req && !fault_class1 && !fault_class2
    |=> !motion_enable && current_limit != 16'hffff)
    else $error("halt ignored");
  a_hold_powered: assert property (
    pos_hold |-> amp_enable && !motion_enable) else $error("hold unpowered");
  a_resume_runs: assert property (
    resume_move && enable_req && !fault_class1 && !fault_class2
    |=> motion_enable) else $error("no resume");
  a_brake_routed: assert property (
    brake_release |-> brake_assigned && amp_enable)
    else $error("release unrouted");
  a_motion_powered: assert property (
    motion_enable |-> amp_enable && (brake_release || !brake_assigned))
    else $error("motion no release");
  a_apply_order: assert property (
    $fell(enable_req) && motion_enable |=> !brake_release && amp_enable)
    else $error("apply order");
  c_resume: cover property (resume_move);
  c_ov: cover property ($rose(ov_fault));
  c_hold: cover property (pos_hold && fault_class1);
endmodule
bind shbs_top shbs_properties shbs_properties_i (.*);

// *** verification/shbs_plant.sv ***
// Purpose: motor, position compensation and brake controller stand-in
// Assumes: motor coasts to rest six cycles after motion stops
// Notes:   compensation always answers one cycle late
`timescale 1ns/100ps
module shbs_plant #(
  parameter bit VRED = 1'b1 // voltage reduction switch
) (
  input  wire logic clk,            // system clock
  input  wire logic rstn,           // power-up reset, active low
  input  wire logic motion_enable,  // profile may move
  input  wire logic pos_comp_start, // compensation request
  input  wire logic brake_release,  // brake release command
  output logic      standstill,     // motor at rest
  output logic      comp_done,      // compensation finished
  output logic      brake_low       // reduced brake voltage
);
  logic [3:0] rest_q;
  logic [3:0] brk_q;
  always_ff @(posedge clk) begin
    rest_q <= (!rstn || motion_enable) ? 4'h0
                                       : rest_q + {3'h0, rest_q != 4'hf};
    comp_done <= rstn && pos_comp_start;
    // brake unpowered until released, also at power-up
    brk_q <= (!rstn || !brake_release) ? 4'h0
                                       : brk_q + {3'h0, brk_q != 4'hf};
  end
  assign standstill = rest_q > 4'h5;
  assign brake_low = VRED && brk_q == 4'hf;
endmodule

// *** verification/testbench.sv ***
// Purpose: self-checking bench for shbs_top
// Assumes: one millisecond shortened to four cycles
// Notes:   inputs move 2 ns after the rising edge
`timescale 1ns/100ps
module testbench;
  import shbs_pkg::*;
  typedef struct {logic [15:0] a, d, e;} shbs_row_t;
  logic clk = 0, rstn = 0, enable_req = 0, fault_class1 = 0, fault_class2 = 0;
  logic sw_stop = 0, fault_reset = 0, halt_sw_req = 0, halt_n = 1;
  logic mode_end = 0, dc_overvoltage = 0, brake_assigned = 1;
  logic par_wr = 0, par_rd = 0, standstill, comp_done, amp_enable;
  logic brake_release, motion_enable, pos_comp_start, pos_hold;
  logic resume_move, ov_fault;
  logic [15:0] par_addr = 0, par_wdata = 0, par_rdata, current_limit;
  int err_total = 0, n_compared = 0, k;
  shbs_row_t rows [7] = '{'{16'h050e, 16'h07d0, 16'h03e8},
    '{16'h050e, 16'h0002, 16'h0002}, '{16'h0510, 16'h0002, 16'h0002},
    '{16'h110a, 16'h012c, 16'h012c}, '{16'h110c, 16'h00c8, 16'h00c8},
    '{16'h0123, 16'h5a5a, 16'h0000}, '{16'h0600, 16'hffff, 16'h0000}};
  shbs_top #(.TICK_CYCLES(4)) shbs_top_i (.*);
  shbs_plant shbs_plant_i (.*, .brake_low());
  always #10 clk = ~clk;
  task automatic final_report;
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk1(input logic g, e, input string m);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic chk16(input logic [15:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t %s %h", $time, m, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [15:0] a, d);
    par_addr = a;
    par_wdata = d;
    par_wr = 1;
    cyc(1);
    par_wr = 0;
  endtask
  task automatic rdchk(input logic [15:0] a, e);
    par_addr = a;
    par_rd = 1;
    cyc(1);
    par_rd = 0;
    chk16(par_rdata, e, "read");
    cyc(1);
  endtask
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  initial begin
    cyc(4);
    rstn = 1;
    chk16(current_limit, 16'hffff, "reset limit");
    rdchk(16'h050e, 16'h0000);
    rdchk(16'h0510, 16'h0000);
    rdchk(16'h110a, 16'h0064);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    enable_req = 1;
    cyc(2);
    chk1(brake_release && !motion_enable, 1, "release first");
    for (k = 2; k < 99 && motion_enable !== 1'b1; k++) cyc(1);
    chk1(k >= 8 && k <= 12, 1, "release delay");
    brake_assigned = 0;
    cyc(1);
    chk1(!brake_release && amp_enable, 1, "unrouted");
    brake_assigned = 1;
    for (int s = 0; s < 2; s++) begin
      if (s == 0) halt_n = 0;
      else halt_sw_req = 1;
      cyc(2);
      chk16(current_limit, 16'h00c8, "halt limit");
      // first pass withdraws the halt while still braking
      halt_n = 1;
      cyc(2);
      chk1(motion_enable, 0, "early accel");
      for (k = 0; k < 99 && pos_comp_start !== 1'b1; k++) cyc(1);
      chk1(pos_comp_start && !pos_hold && amp_enable, 1, "comp");
      for (k = 0; k < 99 && pos_hold !== 1'b1; k++) cyc(1);
      chk1(pos_hold && amp_enable && standstill, 1, "halt hold");
      chk1(resume_move, s == 0, "resume pulse");
      halt_sw_req = 0;
      for (k = 0; k < 99 && motion_enable !== 1'b1; k++) cyc(1);
      chk1(motion_enable, 1, "resume");
    end
    for (int s = 0; s < 2; s++) begin
      if (s == 0) fault_class1 = 1;
      else sw_stop = 1;
      cyc(1);
      sw_stop = 0;
      cyc(1);
      chk16(current_limit, 16'h012c, "stop limit");
      for (k = 0; k < 99 && standstill !== 1'b1; k++) cyc(1);
      cyc(2);
      chk1(amp_enable && (pos_hold || s == 1), 1, "stop hold");
      fault_class1 = 0;
      fault_reset = 1;
      cyc(1);
      fault_reset = 0;
      for (k = 0; k < 99 && motion_enable !== 1'b1; k++) cyc(1);
      chk1(motion_enable, 1, "restart");
    end
    enable_req = 0;
    cyc(1);
    chk1(amp_enable && !brake_release, 1, "apply");
    cyc(14);
    enable_req = 1;
    for (k = 0; k < 99 && motion_enable !== 1'b1; k++) cyc(1);
    halt_n = 0;
    cyc(2);
    dc_overvoltage = 1;
    cyc(2);
    chk1(!amp_enable && ov_fault, 1, "overvoltage");
    dc_overvoltage = 0;
    halt_n = 1;
    fault_reset = 1;
    cyc(1);
    fault_reset = 0;
    cyc(1);
    chk1(ov_fault, 0, "ov clear");
    for (k = 0; k < 99 && motion_enable !== 1'b1; k++) cyc(1);
    mode_end = 1;
    cyc(1);
    mode_end = 0;
    cyc(1);
    chk16(current_limit, 16'h00c8, "mode end limit");
    for (k = 0; k < 99 && pos_hold !== 1'b1; k++) cyc(1);
    cyc(3);
    chk1(pos_hold && !motion_enable, 1, "mode end hold");
    rdchk(16'h0600, 16'h008b);
    enable_req = 0;
    cyc(1);
    chk1(amp_enable && !brake_release, 1, "hold apply");
    for (k = 0; k < 99 && amp_enable !== 1'b0; k++) cyc(1);
    enable_req = 1;
    for (k = 0; k < 99 && motion_enable !== 1'b1; k++) cyc(1);
    fault_class2 = 1;
    cyc(3);
    chk1(amp_enable && !standstill, 1, "class 2 early");
    for (k = 0; k < 99 && brake_release !== 1'b0; k++) cyc(1);
    chk1(standstill && amp_enable, 1, "class 2 rest");
    for (k = 0; k < 99 && amp_enable !== 1'b0; k++) cyc(1);
    chk1(k >= 6 && k <= 11, 1, "apply delay");
    rstn = 0;
    cyc(2);
    rstn = 1;
    chk1(amp_enable || brake_release || ov_fault, 0, "reset outs");
    rdchk(16'h050e, 16'h0000);
    rdchk(16'h110c, 16'h0064);
    final_report();
  end
endmodule
